// [hdl/hicpp_parser.sv]
`include "hicpp_defs.svh"
`default_nettype none

module hicpp_parser
  import hicpp_pkg::*;
#(
  parameter logic [7:0] FILLER_CODE = 8'h00,
  parameter logic [7:0] PIXEL_ENABLE_CODE = 8'h01
)
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_serial_clock,
  input wire logic i_parallel_serial_strap,
  input wire logic i_host_family_strap,
  input wire logic i_chip_select_n,
  input wire logic i_data_or_command_flag,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic i_hardware_reset_in_n,
  input wire logic i_serial_data_line,
  input wire logic [23:0] i_data,
  output logic [23:0] o_data,
  output logic [23:0] o_data_oe,
  input wire hicpp_width_t i_bus_width_setting,
  input wire logic i_pixel_write_strobe,
  input wire hicpp_lcdc_t i_lcdc,
  output logic [7:0] o_lookup_command,
  input wire hicpp_lookup_t i_lookup,
  input wire logic [7:0] i_read_param,
  input wire logic [23:0] i_read_pixel,
  output hicpp_command_t o_command,
  output hicpp_latch_t o_latch,
  output hicpp_pixel_t o_host_pixel,
  output hicpp_pixel_t o_lcdc_pixel,
  output logic o_frame_sync,
  output logic o_line_sync,
  output logic o_pixel_port_enabled,
  output hicpp_mode_t o_mode
);

  localparam int IW = $clog2(`HICPP_MAX_PARAMS);

  // Pixel mask for the configured width; unused lines read as zero.
  function automatic logic [23:0] width_mask(input hicpp_width_t width);
    logic [23:0] mask;
    mask = `HICPP_MASK_8;
    unique case (width)
      HICPP_W8: mask = `HICPP_MASK_8;
      HICPP_W9: mask = `HICPP_MASK_9;
      HICPP_W12: mask = `HICPP_MASK_12;
      HICPP_W16: mask = `HICPP_MASK_16;
      HICPP_W18: mask = `HICPP_MASK_18;
      HICPP_W24: mask = `HICPP_MASK_24;
      default: mask = `HICPP_MASK_8;
    endcase
    return mask;
  endfunction

  // Serial link domain, clocked by the host serial clock.

  logic ser_family_s1_reg;
  logic ser_family_s2_reg;
  logic [3:0] bit_count_reg;
  logic [3:0] bit_count_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic frame_toggle_reg;
  logic frame_toggle_next;
  logic [8:0] frame_word_reg;
  logic [8:0] frame_word_next;
  wire logic ser_arst;

  // Deselect clears the bit position so a torn frame never shifts into the next.
  assign ser_arst = i_rst | i_chip_select_n;

  // Shift on every rising edge; the word is published with a toggle at the last bit.
  always_comb
  begin
    shift_next = {shift_reg[6:0], i_serial_data_line};
    bit_count_next = bit_count_reg + 4'h1;
    frame_toggle_next = frame_toggle_reg;
    frame_word_next = frame_word_reg;
    if (bit_count_reg == (ser_family_s2_reg ? `HICPP_SER4_LAST_BIT : `HICPP_SER3_LAST_BIT))
    begin
      bit_count_next = 4'h0;
      frame_toggle_next = ~frame_toggle_reg;
      if (ser_family_s2_reg)
      begin
        frame_word_next = {i_data_or_command_flag, shift_reg[6:0], i_serial_data_line};
      end
      else
      begin
        frame_word_next = {shift_reg, i_serial_data_line};
      end
    end
  end

  // Frame position state, cleared whenever chip select goes high.
  always_ff @(posedge i_serial_clock or posedge ser_arst)
  begin
    if (ser_arst)
    begin
      bit_count_reg <= 4'h0;
      shift_reg <= 8'h00;
    end
    else
    begin
      bit_count_reg <= bit_count_next;
      shift_reg <= shift_next;
    end
  end

  // The toggle survives deselect; clearing it there would fake an event in the core.
  always_ff @(posedge i_serial_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      ser_family_s1_reg <= 1'b0;
      ser_family_s2_reg <= 1'b0;
      frame_toggle_reg <= 1'b0;
      frame_word_reg <= 9'h000;
    end
    else
    begin
      ser_family_s1_reg <= i_host_family_strap;
      ser_family_s2_reg <= ser_family_s1_reg;
      frame_toggle_reg <= frame_toggle_next;
      frame_word_reg <= frame_word_next;
    end
  end

  // Core domain synchronisers.

  hicpp_pins_t pins_raw;
  hicpp_pins_t pins_s1_reg;
  hicpp_pins_t pins;
  logic toggle_s1_reg;
  logic toggle_s2_reg;
  logic toggle_s3_reg;
  logic strobe_s3_reg;

  assign pins_raw = {i_pixel_write_strobe, i_lcdc, i_hardware_reset_in_n, i_chip_select_n,
                     i_data_or_command_flag, i_read_strobe_n, i_write_strobe_n,
                     i_parallel_serial_strap, i_host_family_strap, i_data};

  // Two flops on every pin and on the frame toggle before any logic looks at them.
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      pins_s1_reg <= `HICPP_PINS_RESET;
      pins <= `HICPP_PINS_RESET;
      toggle_s1_reg <= 1'b0;
      toggle_s2_reg <= 1'b0;
      toggle_s3_reg <= 1'b0;
      strobe_s3_reg <= 1'b0;
    end
    else
    begin
      pins_s1_reg <= pins_raw;
      pins <= pins_s1_reg;
      toggle_s1_reg <= frame_toggle_reg;
      toggle_s2_reg <= toggle_s1_reg;
      toggle_s3_reg <= toggle_s2_reg;
      strobe_s3_reg <= pins.pixel_write_strobe;
    end
  end

  // Mode decode from the synchronised straps.
  hicpp_mode_t mode;
  logic serial_mode;

  always_comb
  begin
    if (pins.parallel_serial_strap)
    begin
      mode = pins.host_family_strap ? HICPP_PAR68 : HICPP_PAR80;
    end
    else
    begin
      mode = pins.host_family_strap ? HICPP_SER4 : HICPP_SER3;
    end
  end

  assign serial_mode = ~pins.parallel_serial_strap;
  assign o_mode = mode;

  // Parallel host bus.

  logic wr_active;
  logic rd_active;
  logic wr_prev_reg;
  logic wr_prev_next;
  logic [23:0] data_hold_reg;
  logic [23:0] data_hold_next;
  logic flag_hold_reg;
  logic flag_hold_next;
  logic [23:0] read_data_reg;
  logic [23:0] read_data_next;
  logic [23:0] drive_mask_reg;
  logic [23:0] drive_mask_next;
  logic pending_reg;
  hicpp_kind_t kind_reg;
  logic pixel_en_reg;
  logic pixel_port_on;

  // Both strobes count only inside chip select; the 68 family uses enable plus direction.
  always_comb
  begin
    if (mode == HICPP_PAR68)
    begin
      wr_active = ~pins.chip_select_n & pins.read_strobe_n & ~pins.write_strobe_n;
      rd_active = ~pins.chip_select_n & pins.read_strobe_n & pins.write_strobe_n;
    end
    else
    begin
      wr_active = ~pins.chip_select_n & ~pins.write_strobe_n;
      rd_active = ~pins.chip_select_n & ~pins.read_strobe_n;
    end
  end

  assign pixel_port_on = serial_mode | pixel_en_reg;

  // Data and flag are held through the strobe; the write lands when the overlap ends.
  always_comb
  begin
    wr_prev_next = wr_active & ~serial_mode;
    data_hold_next = wr_active ? pins.data : data_hold_reg;
    flag_hold_next = wr_active ? pins.data_or_command_flag : flag_hold_reg;
    read_data_next = read_data_reg;
    drive_mask_next = 24'h00_0000;
    // The bus stays an input while the pixel port owns it.
    if (rd_active & ~serial_mode & ~pixel_port_on & pins.hardware_reset_in_n)
    begin
      if (!pins.data_or_command_flag)
      begin
        read_data_next = {16'h0000, `HICPP_DUMMY_BYTE};
        drive_mask_next = `HICPP_LOW_BYTE_MASK;
      end
      else if (pending_reg && kind_reg == HICPP_KIND_PIXEL)
      begin
        read_data_next = i_read_pixel & width_mask(i_bus_width_setting);
        drive_mask_next = `HICPP_FULL_MASK;
      end
      else
      begin
        read_data_next = {16'h0000, i_read_param};
        drive_mask_next = `HICPP_LOW_BYTE_MASK;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_prev_reg <= 1'b0;
      data_hold_reg <= 24'h00_0000;
      flag_hold_reg <= 1'b0;
      read_data_reg <= 24'h00_0000;
      drive_mask_reg <= 24'h00_0000;
    end
    else
    begin
      wr_prev_reg <= wr_prev_next;
      data_hold_reg <= data_hold_next;
      flag_hold_reg <= flag_hold_next;
      read_data_reg <= read_data_next;
      drive_mask_reg <= drive_mask_next;
    end
  end

  assign o_data = read_data_reg;
  assign o_data_oe = drive_mask_reg;

  // Transfer events from either host path.

  logic evt_valid;
  logic evt_cmd;
  logic [7:0] evt_byte;
  logic [23:0] evt_word;

  // Commands and parameters use the low byte only; serial pixels are 8 bits wide.
  always_comb
  begin
    if (serial_mode)
    begin
      evt_valid = (toggle_s2_reg ^ toggle_s3_reg) & pins.hardware_reset_in_n;
      evt_cmd = ~frame_word_reg[8];
      evt_byte = frame_word_reg[7:0];
      evt_word = {16'h0000, frame_word_reg[7:0]};
    end
    else
    begin
      evt_valid = wr_prev_reg & ~wr_active & pins.hardware_reset_in_n;
      evt_cmd = ~flag_hold_reg;
      evt_byte = data_hold_reg[7:0];
      evt_word = data_hold_reg;
    end
  end

  assign o_lookup_command = evt_byte;

  // Packet parser.

  logic pending_next;
  logic [7:0] command_reg;
  logic [7:0] command_next;
  hicpp_kind_t kind_next;
  logic [3:0] count_reg;
  logic [3:0] count_next;
  logic [3:0] first_reg;
  logic [3:0] first_next;
  logic [3:0] index_reg;
  logic [3:0] index_next;
  logic [`HICPP_MAX_PARAMS-1:0][7:0] staged_reg;
  logic [`HICPP_MAX_PARAMS-1:0][7:0] staged_next;
  logic pixel_en_next;
  hicpp_latch_t latch_reg;
  hicpp_latch_t latch_next;
  hicpp_command_t command_out_reg;
  hicpp_command_t command_out_next;
  hicpp_pixel_t host_pixel_reg;
  hicpp_pixel_t host_pixel_next;
  logic per_param;
  logic last_param;

  assign per_param = (kind_reg == HICPP_KIND_SINGLE) || (kind_reg == HICPP_KIND_MIXED && index_reg < first_reg);
  assign last_param = (index_reg + 4'h1) == count_reg;

  // One event per cycle at most; any command except a filler inside a pending packet restarts the packet state.
  always_comb
  begin
    pending_next = pending_reg;
    command_next = command_reg;
    kind_next = kind_reg;
    count_next = count_reg;
    first_next = first_reg;
    index_next = index_reg;
    staged_next = staged_reg;
    pixel_en_next = pixel_en_reg;
    latch_next = latch_reg;
    latch_next.valid = 1'b0;
    command_out_next = '{valid: 1'b0, code: command_reg};
    host_pixel_next = host_pixel_reg;
    host_pixel_next.valid = 1'b0;
    if (!pins.hardware_reset_in_n)
    begin
      pending_next = 1'b0;
    end
    else if (evt_valid && evt_cmd)
    begin
      // A filler keeps the pending packet alive as a pure wait state.
      if (!(evt_byte == FILLER_CODE && pending_reg))
      begin
        // Staged range values are dropped here, so nothing of a torn set lands.
        command_next = evt_byte;
        kind_next = i_lookup.kind;
        count_next = i_lookup.count;
        first_next = i_lookup.range_first;
        index_next = 4'h0;
        pending_next = i_lookup.count != 4'h0 || i_lookup.kind == HICPP_KIND_PIXEL;
        if (i_lookup.kind == HICPP_KIND_CMD_ONLY || i_lookup.kind == HICPP_KIND_SINGLE
            || i_lookup.kind == HICPP_KIND_PIXEL || i_lookup.count == 4'h0)
        begin
          command_out_next = '{valid: 1'b1, code: evt_byte};
          pending_next = pending_next & (i_lookup.kind != HICPP_KIND_CMD_ONLY);
        end
      end
    end
    else if (evt_valid && pending_reg)
    begin
      if (kind_reg == HICPP_KIND_PIXEL)
      begin
        host_pixel_next = '{valid: 1'b1, data: evt_word & width_mask(i_bus_width_setting)};
      end
      // Parameters past the defined count find no pending packet and fall away.
      else if (index_reg < count_reg && index_reg < 4'(`HICPP_MAX_PARAMS))
      begin
        staged_next[index_reg[IW-1:0]] = evt_byte;
        index_next = index_reg + 4'h1;
        pending_next = ~last_param;
        if (per_param)
        begin
          latch_next = '{valid: 1'b1, command: command_reg, first: index_reg, count: 4'h1,
                         values: staged_next};
        end
        else if (last_param)
        begin
          latch_next.valid = 1'b1;
          latch_next.command = command_reg;
          latch_next.first = (kind_reg == HICPP_KIND_MIXED) ? first_reg : 4'h0;
          latch_next.count = (kind_reg == HICPP_KIND_MIXED) ? count_reg - first_reg : count_reg;
          latch_next.values = staged_next;
          command_out_next = '{valid: 1'b1, code: command_reg};
        end
      end
    end
    // The pixel port switch takes effect only when its parameter is committed.
    if (latch_next.valid && latch_next.command == PIXEL_ENABLE_CODE && latch_next.first == 4'h0)
    begin
      pixel_en_next = latch_next.values[0][0];
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      pending_reg <= 1'b0;
      command_reg <= 8'h00;
      kind_reg <= HICPP_KIND_CMD_ONLY;
      count_reg <= 4'h0;
      first_reg <= 4'h0;
      index_reg <= 4'h0;
      staged_reg <= '0;
      pixel_en_reg <= 1'b0;
      latch_reg <= '0;
      command_out_reg <= '0;
      host_pixel_reg <= '0;
    end
    else
    begin
      pending_reg <= pending_next;
      command_reg <= command_next;
      kind_reg <= kind_next;
      count_reg <= count_next;
      first_reg <= first_next;
      index_reg <= index_next;
      staged_reg <= staged_next;
      pixel_en_reg <= pixel_en_next;
      latch_reg <= latch_next;
      command_out_reg <= command_out_next;
      host_pixel_reg <= host_pixel_next;
    end
  end

  assign o_latch = latch_reg;
  assign o_command = command_out_reg;
  assign o_host_pixel = host_pixel_reg;
  assign o_pixel_port_enabled = pixel_port_on;

  // Pixel port.

  logic strobe_rise;
  logic frame_sync_reg;
  logic frame_sync_next;
  logic line_sync_reg;
  logic line_sync_next;
  hicpp_pixel_t lcdc_pixel_reg;
  hicpp_pixel_t lcdc_pixel_next;

  // The strobe is oversampled, so it must stay well below half the core clock rate.
  assign strobe_rise = pins.pixel_write_strobe & ~strobe_s3_reg;

  // Sync and data are taken in the same sample as the strobe edge.
  always_comb
  begin
    frame_sync_next = 1'b0;
    line_sync_next = 1'b0;
    lcdc_pixel_next = '{valid: 1'b0, data: lcdc_pixel_reg.data};
    if (strobe_rise && pixel_port_on)
    begin
      frame_sync_next = ~pins.lcdc.vertical_sync;
      line_sync_next = pins.lcdc.vertical_sync & ~pins.lcdc.horizontal_sync;
      // A word during vertical sync belongs to blanking, never to the active line.
      if (pins.lcdc.vertical_sync && pins.lcdc.horizontal_sync && pins.lcdc.pixel_data_valid)
      begin
        lcdc_pixel_next = '{valid: 1'b1, data: pins.data & width_mask(i_bus_width_setting)};
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      frame_sync_reg <= 1'b0;
      line_sync_reg <= 1'b0;
      lcdc_pixel_reg <= '0;
    end
    else
    begin
      frame_sync_reg <= frame_sync_next;
      line_sync_reg <= line_sync_next;
      lcdc_pixel_reg <= lcdc_pixel_next;
    end
  end

  assign o_frame_sync = frame_sync_reg;
  assign o_line_sync = line_sync_reg;
  assign o_lcdc_pixel = lcdc_pixel_reg;

endmodule

`default_nettype wire

// [hdl/hicpp_defs.svh]
`ifndef HICPP_DEFS_SVH
`define HICPP_DEFS_SVH

// Deepest parameter set that one command can stage before a range commit.
`define HICPP_MAX_PARAMS 8
// Width of the parameter index and parameter count fields.
`define HICPP_INDEX_W 4

// Value driven on the low byte when a read is made with the flag low.
`define HICPP_DUMMY_BYTE 8'h00

// Last bit position of a serial frame: 8 bits in four-wire, 9 bits in three-wire.
`define HICPP_SER4_LAST_BIT 4'h7
`define HICPP_SER3_LAST_BIT 4'h8

// Drive masks of the shared data bus.
`define HICPP_LOW_BYTE_MASK 24'h00_00ff
`define HICPP_FULL_MASK 24'hff_ffff

// Pixel port data masks, one per bus width setting, filled from the low line.
`define HICPP_MASK_8 24'h00_00ff
`define HICPP_MASK_9 24'h00_01ff
`define HICPP_MASK_12 24'h00_0fff
`define HICPP_MASK_16 24'h00_ffff
`define HICPP_MASK_18 24'h03_ffff
`define HICPP_MASK_24 24'hff_ffff

// Reset value of the pin synchroniser: chip select and both strobes idle high.
`define HICPP_PINS_RESET 35'h0_2c00_0000

`endif

// [hdl/hicpp_pkg.sv]
`include "hicpp_defs.svh"
`default_nettype none

package hicpp_pkg;

  // Host mode chosen by the two straps.
  typedef enum logic [1:0] {HICPP_PAR80, HICPP_PAR68, HICPP_SER4, HICPP_SER3} hicpp_mode_t;

  // Packet handling of a command, supplied by the command table outside.
  typedef enum logic [2:0] {
    HICPP_KIND_CMD_ONLY,
    HICPP_KIND_SINGLE,
    HICPP_KIND_RANGE,
    HICPP_KIND_TRIGGER,
    HICPP_KIND_MIXED,
    HICPP_KIND_PIXEL
  } hicpp_kind_t;

  // Bus width setting of the pixel port and the parallel pixel path.
  typedef enum logic [2:0] {HICPP_W8, HICPP_W9, HICPP_W12, HICPP_W16, HICPP_W18, HICPP_W24} hicpp_width_t;

  // Answer of the command table for the byte on o_lookup_command.
  typedef struct packed {
    hicpp_kind_t kind;
    logic [`HICPP_INDEX_W-1:0] count;
    logic [`HICPP_INDEX_W-1:0] range_first;
  } hicpp_lookup_t;

  // Parameter commit: values[first .. first+count-1] become effective.
  typedef struct packed {
    logic valid;
    logic [7:0] command;
    logic [`HICPP_INDEX_W-1:0] first;
    logic [`HICPP_INDEX_W-1:0] count;
    logic [`HICPP_MAX_PARAMS-1:0][7:0] values;
  } hicpp_latch_t;

  // Command execution pulse.
  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } hicpp_command_t;

  // One pixel word.
  typedef struct packed {
    logic valid;
    logic [23:0] data;
  } hicpp_pixel_t;

  // Sync and valid pins of the pixel port.
  typedef struct packed {
    logic vertical_sync;
    logic horizontal_sync;
    logic pixel_data_valid;
  } hicpp_lcdc_t;

  // Every asynchronous pin that the core clock samples, MSB first.
  typedef struct packed {
    logic pixel_write_strobe;
    hicpp_lcdc_t lcdc;
    logic hardware_reset_in_n;
    logic chip_select_n;
    logic data_or_command_flag;
    logic read_strobe_n;
    logic write_strobe_n;
    logic parallel_serial_strap;
    logic host_family_strap;
    logic [23:0] data;
  } hicpp_pins_t;

endpackage

`default_nettype wire

// [tb/hicpp_table_model.sv]
`default_nettype none
// Command table standing beside the parser; it answers in the same cycle as the lookup.
module hicpp_table_model
  import hicpp_pkg::*;
(
  input wire logic [7:0] i_code,
  output hicpp_lookup_t o_lookup
);
  timeunit 1ns;
  timeprecision 1ps;
  // Unknown codes act as bare commands, so a stray byte never leaves a packet open.
  always_comb
  begin
    o_lookup = '{HICPP_KIND_CMD_ONLY, 4'h0, 4'h0};
    case (i_code)
      8'h20: o_lookup = '{HICPP_KIND_SINGLE, 4'h2, 4'h0};
      8'h30: o_lookup = '{HICPP_KIND_RANGE, 4'h2, 4'h0};
      8'h40: o_lookup = '{HICPP_KIND_TRIGGER, 4'h1, 4'h0};
      8'h50: o_lookup = '{HICPP_KIND_MIXED, 4'h3, 4'h1};
      8'h01: o_lookup = '{HICPP_KIND_SINGLE, 4'h1, 4'h0};
      8'h60: o_lookup = '{HICPP_KIND_PIXEL, 4'h0, 4'h0};
      default: ;
    endcase
  end
endmodule
`default_nettype wire

// [tb/hicpp_parser_properties.sv]
`default_nettype none
module hicpp_parser_checker
  import hicpp_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_chip_select_n,
  input wire logic i_hardware_reset_in_n,
  input wire logic i_parallel_serial_strap,
  input wire logic i_host_family_strap,
  input wire hicpp_width_t i_bus_width_setting,
  input wire logic [23:0] o_data_oe,
  input wire hicpp_mode_t o_mode,
  input wire logic o_pixel_port_enabled,
  input wire hicpp_pixel_t o_lcdc_pixel,
  input wire logic o_frame_sync,
  input wire logic o_line_sync,
  input wire hicpp_command_t o_command,
  input wire hicpp_latch_t o_latch
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // Release windows allow for the pin synchroniser and the registered enable.
  desel_release_a: assert property (i_chip_select_n [*5] |-> o_data_oe == 24'h00_0000)
    else $error("Data bus driven while deselected.");
  hwres_release_a: assert property (!i_hardware_reset_in_n [*5] |-> o_data_oe == 24'h00_0000)
    else $error("Data bus driven during hardware reset.");
  mode_four_a: assert property ((!i_parallel_serial_strap && i_host_family_strap) [*4] |-> o_mode == HICPP_SER4)
    else $error("Four-wire mode not selected.");
  mode_three_a: assert property ((!i_parallel_serial_strap && !i_host_family_strap) [*4] |-> o_mode == HICPP_SER3)
    else $error("Three-wire mode not selected.");
  serial_port_a: assert property (!i_parallel_serial_strap [*3] |-> o_pixel_port_enabled)
    else $error("Pixel port off in serial mode.");
  width_mask_a: assert property (o_lcdc_pixel.valid && i_bus_width_setting == HICPP_W16 |-> o_lcdc_pixel.data[23:16] == 8'h00)
    else $error("Pixel bits above the width setting.");
  pixel_gate_a: assert property (o_lcdc_pixel.valid |-> o_pixel_port_enabled && !o_frame_sync && !o_line_sync)
    else $error("Pixel accepted outside the active line.");
  sync_excl_a: assert property (o_frame_sync |-> !o_line_sync && !$past(o_frame_sync))
    else $error("Frame sync malformed.");
  latch_bound_a: assert property (o_latch.valid |-> {1'b0, o_latch.first} + {1'b0, o_latch.count} <= 5'h08)
    else $error("Latch beyond parameter set.");
  cmd_pulse_a: assert property (o_command.valid |=> !o_command.valid)
    else $error("Command pulse too long.");
  cover property (o_latch.valid && o_latch.count == 4'h2);
  cover property (o_frame_sync);
  cover property (o_lcdc_pixel.valid);
endmodule

bind hicpp_parser hicpp_parser_checker u_chk (.i_clock(i_clock), .i_rst(i_rst), .i_chip_select_n(i_chip_select_n),
  .i_hardware_reset_in_n(i_hardware_reset_in_n), .i_parallel_serial_strap(i_parallel_serial_strap),
  .i_host_family_strap(i_host_family_strap), .i_bus_width_setting(i_bus_width_setting), .o_data_oe(o_data_oe),
  .o_mode(o_mode), .o_pixel_port_enabled(o_pixel_port_enabled), .o_lcdc_pixel(o_lcdc_pixel),
  .o_frame_sync(o_frame_sync), .o_line_sync(o_line_sync), .o_command(o_command), .o_latch(o_latch));
`default_nettype wire

// [tb/hicpp_parser_tb_top.sv]
`default_nettype none
module hicpp_parser_tb_top
  import hicpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clock = 0, i_rst = 1, sclk = 0, ps = 0, fam = 1, cs_n = 1, flag = 0, hw_n = 1, sd = 0, stb = 0;
  logic rd_n = 1, wr_n = 1;
  logic [23:0] din = 24'h00_0000;
  logic [23:0] dout, doe, last_hpx;
  hicpp_width_t bw = HICPP_W16;
  hicpp_lcdc_t lc = '{1, 1, 1};
  logic [7:0] lk;
  hicpp_lookup_t lu;
  hicpp_command_t cmd;
  hicpp_latch_t lat, last_lat;
  hicpp_pixel_t lpx, hpx;
  logic fs, ls, ppe;
  hicpp_mode_t md;
  logic [7:0] last_cmd;
  logic [23:0] last_pix;
  int n_mismatch = 0, cmp_count = 0, n_cmd = 0, n_lat = 0, n_pix = 0, n_fs = 0, n_ls = 0;

  always #5 i_clock = ~i_clock;

  hicpp_parser dut (.i_clock(i_clock), .i_rst(i_rst), .i_serial_clock(sclk), .i_parallel_serial_strap(ps),
    .i_host_family_strap(fam), .i_chip_select_n(cs_n), .i_data_or_command_flag(flag), .i_read_strobe_n(rd_n),
    .i_write_strobe_n(wr_n), .i_hardware_reset_in_n(hw_n), .i_serial_data_line(sd), .i_data(din), .o_data(dout),
    .o_data_oe(doe), .i_bus_width_setting(bw), .i_pixel_write_strobe(stb), .i_lcdc(lc),
    .o_lookup_command(lk), .i_lookup(lu), .i_read_param(8'hC3), .i_read_pixel(24'h00_0000), .o_command(cmd),
    .o_latch(lat), .o_host_pixel(hpx), .o_lcdc_pixel(lpx), .o_frame_sync(fs), .o_line_sync(ls),
    .o_pixel_port_enabled(ppe), .o_mode(md));
  hicpp_table_model table_model (.i_code(lk), .o_lookup(lu));

  // Output pulses last one cycle, so they are logged here rather than polled.
  always @(posedge i_clock)
  begin
    if (cmd.valid === 1'b1)
    begin
      n_cmd++;
      last_cmd = cmd.code;
    end
    if (lat.valid === 1'b1)
    begin
      n_lat++;
      last_lat = lat;
    end
    if (lpx.valid === 1'b1)
    begin
      n_pix++;
      last_pix = lpx.data;
    end
    if (fs === 1'b1)
      n_fs++;
    if (ls === 1'b1)
      n_ls++;
    if (hpx.valid === 1'b1)
      last_hpx = hpx.data;
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One serial frame; the link clock only runs inside the frame.
  task automatic ser(input logic c, input logic f, input logic [7:0] b);
    logic [8:0] bits;
    int nb;
    bits = {f, b};
    nb = fam ? 8 : 9;
    @(negedge i_clock);
    cs_n = c;
    // Three-wire frames carry the flag themselves, so the pin shows the opposite to catch misuse.
    flag = fam ? f : ~f;
    for (int i = nb - 1; i >= 0; i--)
    begin
      sd = bits[i];
      #3 sclk = 1;
      #3 sclk = 0;
    end
    #3 cs_n = 1;
    sd = ~sd;
    repeat (10) @(posedge i_clock);
  endtask

  // One pixel word, with strobe phases well above the oversampling minimum.
  task automatic pix(input hicpp_lcdc_t l, input logic [23:0] d);
    @(negedge i_clock);
    lc = l;
    din = d;
    repeat (4) @(negedge i_clock);
    stb = 1;
    repeat (4) @(negedge i_clock);
    stb = 0;
    din = ~d;
    repeat (6) @(negedge i_clock);
  endtask

  // One parallel write; the word lands once the strobe rises inside chip select.
  task automatic pw(input logic f, input logic [23:0] d);
    @(negedge i_clock);
    cs_n = 0;
    flag = f;
    din = d;
    wr_n = 0;
    repeat (4) @(negedge i_clock);
    wr_n = 1;
    repeat (2) @(negedge i_clock);
    cs_n = 1;
    repeat (6) @(negedge i_clock);
  endtask

  // One parallel read; data and drive are looked at while the strobe still stands.
  task automatic pr(input logic f, input logic [23:0] e);
    @(negedge i_clock);
    cs_n = 0;
    flag = f;
    rd_n = 0;
    repeat (5) @(negedge i_clock);
    chk("read data", e, dout);
    chk("read drive", 24'h00_00ff, doe);
    rd_n = 1;
    cs_n = 1;
    repeat (6) @(negedge i_clock);
    chk("released", 0, doe);
  endtask

  task automatic give_verdict;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence: every frame is followed by a settle long enough for the crossing.
  initial
  begin
    repeat (20) @(negedge i_clock);
    i_rst = 0;
    repeat (3) @(negedge i_clock);
    ser(1, 0, 8'h10);
    chk("deselected", 0, n_cmd);
    chk("mode four", HICPP_SER4, md);
    ser(0, 0, 8'h10);
    chk("cmd only", {8'h01, 8'h10}, {8'(n_cmd), last_cmd});
    ser(0, 0, 8'h20);
    ser(0, 1, 8'hAA);
    chk("single", {8'h01, 4'h0, 4'h1, 8'hAA}, {8'(n_lat), last_lat.first, last_lat.count, last_lat.values[0]});
    ser(0, 0, 8'h10);
    ser(0, 1, 8'h77);
    chk("cancel single", {8'h03, 8'h01}, {8'(n_cmd), 8'(n_lat)});
    ser(0, 0, 8'h30);
    ser(0, 1, 8'h11);
    ser(0, 0, 8'h00);
    ser(0, 1, 8'h22);
    chk("range", {8'h02, 4'h0, 4'h2, 16'h2211}, {8'(n_lat), last_lat.first, last_lat.count, last_lat.values[1:0]});
    ser(0, 0, 8'h30);
    ser(0, 1, 8'h33);
    ser(0, 0, 8'h10);
    chk("cancel range", {8'h02, 8'h05}, {8'(n_lat), 8'(n_cmd)});
    ser(0, 0, 8'h40);
    chk("trigger wait", 5, n_cmd);
    ser(0, 1, 8'h44);
    ser(0, 1, 8'h55);
    chk("trigger", {8'h06, 8'h40, 8'h03, 8'h44}, {8'(n_cmd), last_cmd, 8'(n_lat), last_lat.values[0]});
    ser(0, 0, 8'h50);
    ser(0, 1, 8'hA1);
    chk("mixed single", {8'h04, 4'h0, 4'h1}, {8'(n_lat), last_lat.first, last_lat.count});
    ser(0, 1, 8'hA2);
    ser(0, 1, 8'hA3);
    chk("mixed range", {8'h05, 4'h1, 4'h2, 16'hA3A2}, {8'(n_lat), last_lat.first, last_lat.count, last_lat.values[2:1]});
    @(negedge i_clock);
    hw_n = 0;
    repeat (8) @(negedge i_clock);
    hw_n = 1;
    fam = 0;
    ser(1, 0, 8'h10);
    chk("mode three", HICPP_SER3, md);
    ser(0, 0, 8'h30);
    ser(0, 1, 8'h66);
    ser(0, 1, 8'h99);
    chk("three wire", {8'h06, 16'h9966}, {8'(n_lat), last_lat.values[1:0]});
    chk("port on", 1, ppe);
    pix('{1, 1, 1}, 24'hAB_CDEF);
    chk("pixel", {8'h01, 24'h00_CDEF}, {8'(n_pix), last_pix});
    pix('{1, 1, 0}, 24'h12_3456);
    pix('{0, 1, 1}, 24'h65_4321);
    pix('{1, 0, 1}, 24'h00_0000);
    chk("gated", {8'h01, 8'h01, 8'h01}, {8'(n_pix), 8'(n_fs), 8'(n_ls)});
    ps = 1;
    repeat (4) @(negedge i_clock);
    chk("port off", 0, ppe);
    pw(0, 24'hFF_FF30);
    pw(1, 24'hAB_CD5A);
    pw(1, 24'h12_34A5);
    chk("parallel", {8'h07, 16'hA55A}, {8'(n_lat), last_lat.values[1:0]});
    pr(1, 24'h00_00C3);
    pr(0, 24'h00_0000);
    pw(0, 24'h00_0060);
    bw = HICPP_W8;
    pw(1, 24'hAB_CDEF);
    chk("host pixel", 24'h00_00EF, last_hpx);
    pw(0, 24'h00_0001);
    pw(1, 24'h00_0001);
    chk("port enabled", 1, ppe);
    give_verdict();
  end
endmodule
`default_nettype wire
